// file: rtl/ccde_exec.sv
`timescale 1ns/100ps
`default_nettype none
module ccde_exec #(
  parameter int unsigned PRESC_W = 8,
  parameter int unsigned WDT_W   = 8
) (
  input  wire logic                            mclk,               // core clock, 25 MHz
  input  wire logic                            reset_n,            // async reset, active low
  input  wire logic                            instr_valid,        // decoded instruction present
  input  wire logic [2:0]                      op_code,            // ccde_op_e encoding
  input  wire logic [ccde_pkg::FADDR_W-1:0]    instr_addr,         // file register address
  input  wire logic                            instr_dest,         // 0 accumulator, 1 register
  input  wire logic [ccde_pkg::BADDR_W-1:0]    bus_addr,           // register bus address
  input  wire logic [ccde_pkg::DATA_W-1:0]     bus_wdata,          // register bus write data
  input  wire logic                            bus_wr,             // write strobe
  input  wire logic                            bus_rd,             // read strobe
  output logic      [ccde_pkg::DATA_W-1:0]     bus_rdata_r,        // read data, cycle after strobe
  output logic      [ccde_pkg::DATA_W-1:0]     acc_r,              // accumulator
  output logic                                 zero_r,             // zero flag
  output logic                                 carry_r,            // carry flag
  output logic                                 timeout_status_r,   // timeout status bit
  output logic                                 powerdown_status_r, // power-down status bit
  output logic                                 discard_r,          // nop cycle, fetch discarded
  output logic                                 wdt_expire_r        // watchdog overflow pulse
);
  localparam int unsigned W = ccde_pkg::DATA_W;
  localparam int unsigned FADDR_MSB = ccde_pkg::FADDR_W;

  logic [W-1:0]       file_r [ccde_pkg::FILE_N];
  logic [PRESC_W-1:0] shared_prescaler_r;
  logic [WDT_W-1:0]   watchdog_counter_r;
  logic               presc_to_wdt_r;

  ccde_pkg::ccde_op_e op;
  logic               take;
  logic [W-1:0]       rval;
  logic [W-1:0]       result;
  logic               wr_acc;
  logic               wr_reg;
  logic               z_upd;
  logic               z_nxt;
  logic               c_upd;
  logic               c_nxt;
  logic               kick;
  logic               skip_nxt;
  logic [W:0]         diff;
  logic [W-1:0]       daa_lo;
  logic               daa_hi;
  logic               wdt_tick;
  logic               wdt_wrap;

  assign op   = ccde_pkg::ccde_op_e'(op_code);
  // the fetched instruction standing in a nop cycle is dropped
  assign take = instr_valid && !discard_r;
  assign rval = file_r[instr_addr];

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  always_comb begin
    result   = ccde_pkg::BYTE_ZERO;
    wr_acc   = 1'b0;
    wr_reg   = 1'b0;
    z_upd    = 1'b0;
    z_nxt    = zero_r;
    c_upd    = 1'b0;
    c_nxt    = carry_r;
    kick     = 1'b0;
    skip_nxt = 1'b0;
    diff     = {1'b0, rval} - {1'b0, acc_r};
    daa_lo   = acc_r;
    daa_hi   = 1'b0;
    if (take) begin
      unique case (op)
        ccde_pkg::OP_CLEAR_REG: begin
          result = ccde_pkg::BYTE_ZERO;
          wr_reg = 1'b1;
          z_upd  = 1'b1;
          z_nxt  = 1'b1;
        end
        ccde_pkg::OP_INVERT_REG: begin
          result = ~rval;
          wr_acc = !instr_dest;
          wr_reg = instr_dest;
          z_upd  = 1'b1;
          z_nxt  = (result == ccde_pkg::BYTE_ZERO);
        end
        ccde_pkg::OP_WATCHDOG_KICK: begin
          kick = 1'b1;
        end
        ccde_pkg::OP_COMPARE_REG_WITH_ACCUMULATOR: begin
          // difference goes nowhere; only flags change
          z_upd = 1'b1;
          z_nxt = (diff[W-1:0] == ccde_pkg::BYTE_ZERO);
          c_upd = 1'b1;
          c_nxt = !diff[W];
        end
        ccde_pkg::OP_DECIMAL_ADJUST: begin
          // no half carry is kept, so a low digit above 9 is the only low trigger
          if (acc_r[3:0] > ccde_pkg::BCD_MAX) begin
            daa_lo = acc_r + ccde_pkg::ADJ_LOW;
          end
          daa_hi = carry_r || (acc_r > ccde_pkg::BCD_BYTEMAX);
          result = daa_hi ? daa_lo + ccde_pkg::ADJ_HIGH : daa_lo;
          wr_acc = 1'b1;
          c_upd  = 1'b1;
          c_nxt  = daa_hi;
        end
        ccde_pkg::OP_DECREMENT_SKIP_IF_ZERO: begin
          result   = rval - ccde_pkg::BYTE_ONE;
          wr_acc   = !instr_dest;
          wr_reg   = instr_dest;
          skip_nxt = (result == ccde_pkg::BYTE_ZERO);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // file registers and accumulator
  // ----------------------------------------------------------------
  // an instruction write beats a bus write in the same cycle
  always_ff @(posedge mclk) begin
    if (wr_reg) begin
      file_r[instr_addr] <= result;
    end else if (bus_wr && !bus_addr[FADDR_MSB]) begin
      file_r[bus_addr[ccde_pkg::FADDR_W-1:0]] <= bus_wdata;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= ccde_pkg::BYTE_ZERO;
    end else if (wr_acc) begin
      acc_r <= result;
    end else if (bus_wr && bus_addr == ccde_pkg::ADDR_ACC) begin
      acc_r <= bus_wdata;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_r  <= 1'b0;
      carry_r <= 1'b0;
    end else begin
      if (z_upd) begin
        zero_r <= z_nxt;
      end else if (bus_wr && bus_addr == ccde_pkg::ADDR_STATUS) begin
        zero_r <= bus_wdata[ccde_pkg::ST_Z];
      end
      if (c_upd) begin
        carry_r <= c_nxt;
      end else if (bus_wr && bus_addr == ccde_pkg::ADDR_STATUS) begin
        carry_r <= bus_wdata[ccde_pkg::ST_C];
      end
    end
  end

  // the bits come out of reset at 1 as after a clean power-up
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_status_r   <= 1'b1;
      powerdown_status_r <= 1'b1;
    end else if (kick) begin
      timeout_status_r   <= 1'b1;
      powerdown_status_r <= 1'b1;
    end else if (wdt_wrap) begin
      timeout_status_r   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // skip: one nop cycle in place of the prefetched instruction
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= skip_nxt;
    end
  end

  // ----------------------------------------------------------------
  // watchdog and shared prescaler
  // ----------------------------------------------------------------
  assign wdt_tick = !presc_to_wdt_r || (&shared_prescaler_r);
  assign wdt_wrap = wdt_tick && (&watchdog_counter_r) && !kick;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presc_to_wdt_r <= 1'b0;
    end else if (bus_wr && bus_addr == ccde_pkg::ADDR_CTRL) begin
      presc_to_wdt_r <= bus_wdata[ccde_pkg::CT_PRESC_WDT];
    end
  end

  // when not assigned the prescaler serves the timer, modelled here as free running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shared_prescaler_r <= '0;
    end else if (kick && presc_to_wdt_r) begin
      shared_prescaler_r <= '0;
    end else begin
      shared_prescaler_r <= shared_prescaler_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_counter_r <= '0;
      wdt_expire_r       <= 1'b0;
    end else begin
      wdt_expire_r <= wdt_wrap;
      if (kick) begin
        watchdog_counter_r <= '0;
      end else if (wdt_tick) begin
        watchdog_counter_r <= watchdog_counter_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register bus read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata_r <= ccde_pkg::BYTE_ZERO;
    end else if (bus_rd) begin
      bus_rdata_r <= ccde_pkg::BYTE_ZERO;
      if (!bus_addr[FADDR_MSB]) begin
        bus_rdata_r <= file_r[bus_addr[ccde_pkg::FADDR_W-1:0]];
      end else begin
        unique case (bus_addr)
          ccde_pkg::ADDR_STATUS: begin
            bus_rdata_r[ccde_pkg::ST_C]  <= carry_r;
            bus_rdata_r[ccde_pkg::ST_Z]  <= zero_r;
            bus_rdata_r[ccde_pkg::ST_PD] <= powerdown_status_r;
            bus_rdata_r[ccde_pkg::ST_TO] <= timeout_status_r;
          end
          ccde_pkg::ADDR_ACC:   bus_rdata_r <= acc_r;
          ccde_pkg::ADDR_WDT:   bus_rdata_r <= W'(watchdog_counter_r);
          ccde_pkg::ADDR_PRESC: bus_rdata_r <= W'(shared_prescaler_r);
          ccde_pkg::ADDR_CTRL:  bus_rdata_r[ccde_pkg::CT_PRESC_WDT] <= presc_to_wdt_r;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_dec_to_zero;
    take && op == ccde_pkg::OP_DECREMENT_SKIP_IF_ZERO && rval == ccde_pkg::BYTE_ONE;
  endsequence
  sequence s_nop_once;
    discard_r ##1 !discard_r;
  endsequence

  a_clear_zeroes: assert property (take && op == ccde_pkg::OP_CLEAR_REG |=>
      zero_r && file_r[$past(instr_addr)] == ccde_pkg::BYTE_ZERO)
    else $error("clear did not zero register and set zero flag");
  a_invert_to_acc: assert property (take && op == ccde_pkg::OP_INVERT_REG && !instr_dest |=>
      acc_r == ~$past(rval) && zero_r == ($past(rval) == 8'hFF))
    else $error("invert to accumulator wrong");
  a_invert_to_reg: assert property (take && op == ccde_pkg::OP_INVERT_REG && instr_dest |=>
      file_r[$past(instr_addr)] == ~$past(rval) && $stable(acc_r))
    else $error("invert to register wrong");
  a_kick_clears: assert property (take && op == ccde_pkg::OP_WATCHDOG_KICK |=>
      watchdog_counter_r == '0 && (!$past(presc_to_wdt_r) || shared_prescaler_r == '0))
    else $error("kick did not clear watchdog or prescaler");
  a_kick_status: assert property (take && op == ccde_pkg::OP_WATCHDOG_KICK |=>
      timeout_status_r && powerdown_status_r)
    else $error("kick did not set status bits");
  a_cmp_flags: assert property (take && op == ccde_pkg::OP_COMPARE_REG_WITH_ACCUMULATOR |=>
      zero_r == ($past(rval) == $past(acc_r)) && carry_r == ($past(rval) >= $past(acc_r)))
    else $error("compare flags wrong");
  a_cmp_keeps: assert property (take && op == ccde_pkg::OP_COMPARE_REG_WITH_ACCUMULATOR &&
      !bus_wr |=> $stable(acc_r) && file_r[$past(instr_addr)] == $past(rval))
    else $error("compare changed data");
  a_daa_zero_kept: assert property (take && op == ccde_pkg::OP_DECIMAL_ADJUST &&
      !bus_wr |=> $stable(zero_r))
    else $error("decimal adjust touched zero flag");
  a_dec_result: assert property (take && op == ccde_pkg::OP_DECREMENT_SKIP_IF_ZERO
      && !instr_dest |=> acc_r == $past(rval) - ccde_pkg::BYTE_ONE)
    else $error("decrement result wrong");
  a_skip_nop: assert property (s_dec_to_zero |=> s_nop_once)
    else $error("skip did not give one nop cycle");
  a_no_skip: assert property (take && op != ccde_pkg::OP_DECREMENT_SKIP_IF_ZERO |=>
      !discard_r)
    else $error("unexpected nop cycle");
endmodule // ccde_exec
`default_nettype wire

// file: rtl/ccde_pkg.sv
`default_nettype none
package ccde_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 6;
  localparam int unsigned BADDR_W = 7;
  localparam int unsigned FILE_N  = 64;

  // ----------------------------------------------------------------
  // operations presented by the decoder on op_code
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_CLEAR_REG,
    OP_INVERT_REG,
    OP_WATCHDOG_KICK,
    OP_COMPARE_REG_WITH_ACCUMULATOR,
    OP_DECIMAL_ADJUST,
    OP_DECREMENT_SKIP_IF_ZERO
  } ccde_op_e;

  // ----------------------------------------------------------------
  // register map: file registers at 00h..3Fh, then these
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_STATUS  = 7'h40;
  localparam logic [6:0] ADDR_ACC     = 7'h41;
  localparam logic [6:0] ADDR_WDT     = 7'h42;
  localparam logic [6:0] ADDR_PRESC   = 7'h43;
  localparam logic [6:0] ADDR_CTRL    = 7'h44;

  // status fields
  localparam int unsigned ST_C  = 0;
  localparam int unsigned ST_Z  = 2;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_TO = 4;
  // control fields
  localparam int unsigned CT_PRESC_WDT = 0;

  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [7:0] BYTE_ONE    = 8'h01;
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [7:0] ADJ_LOW     = 8'h06;
  localparam logic [7:0] ADJ_HIGH    = 8'h60;
  localparam logic [7:0] BCD_BYTEMAX = 8'h99;
endpackage
`default_nettype wire

// file: sim/ccde_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ccde_exec_tb;
  logic       mclk;
  logic       reset_n;
  logic       instr_valid;
  logic [2:0] op_code;
  logic [5:0] instr_addr;
  logic       instr_dest;
  logic [6:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata_r;
  logic [7:0] acc_r;
  logic       zero_r;
  logic       carry_r;
  logic       timeout_status_r;
  logic       powerdown_status_r;
  logic       discard_r;
  logic       wdt_expire_r;
  logic [7:0] rd;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         fm[64];
  int         m_acc, m_z, m_c, m_sk;
  int         op, a, d, v, n;

  ccde_exec #(.PRESC_W(8), .WDT_W(8)) ccde_exec_inst (
    .mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid), .op_code(op_code),
    .instr_addr(instr_addr), .instr_dest(instr_dest), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r),
    .acc_r(acc_r), .zero_r(zero_r), .carry_r(carry_r), .timeout_status_r(timeout_status_r),
    .powerdown_status_r(powerdown_status_r), .discard_r(discard_r),
    .wdt_expire_r(wdt_expire_r)
  );

  // ----------------------------------------------------------------
  // clock, hang guard, reporting
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // the whole run needs well under half of this
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and instruction drivers, each leaves one idle edge between strobes unless ex is told to hold valid
  // ----------------------------------------------------------------
  task automatic bwr(input logic [6:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    bus_wr    <= 1'b1;
    bus_addr  <= ad;
    bus_wdata <= dt;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  task automatic brd(input logic [6:0] ad);
    @(posedge mclk);
    bus_rd   <= 1'b1;
    bus_addr <= ad;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 rd = bus_rdata_r;
  endtask

  task automatic ex(input int o, input int ra, input int dd, input bit hold);
    @(posedge mclk);
    instr_valid <= 1'b1;
    op_code     <= 3'(o);
    instr_addr  <= 6'(ra);
    instr_dest  <= dd[0];
    @(posedge mclk);
    if (!hold) instr_valid <= 1'b0;
    model(o, ra, dd);
    #1;
  endtask

  function automatic void model(input int o, input int ra, input int dd);
    int r;
    r = 0;
    m_sk = 0;
    case (o)
      0: begin fm[ra] = 0; m_z = 1; end
      1: begin r = ~fm[ra] & 255; m_z = (r == 0); end
      3: begin m_c = fm[ra] >= m_acc; m_z = fm[ra] == m_acc; end
      4: begin
        r = m_acc;
        if ((m_acc & 15) > 9) r += 6;
        if (m_c != 0 || m_acc > 153) begin r += 96; m_c = 1; end else m_c = 0;
        m_acc = r & 255;
      end
      5: begin r = (fm[ra] + 255) & 255; m_sk = (r == 0); end
      default: ;
    endcase
    if (o == 1 || o == 5) begin
      if (dd != 0) fm[ra] = r; else m_acc = r;
    end
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0; instr_valid = 1'b0; op_code = 3'h0; instr_addr = 6'h00;
    instr_dest = 1'b0; bus_addr = 7'h00; bus_wdata = 8'h00; bus_wr = 1'b0; bus_rd = 1'b0;
    m_acc = 0; m_z = 0; m_c = 0; m_sk = 0;
    void'($urandom(32'hC81C92BD));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("acc_rst", acc_r, 8'h00);
    chk("flags_rst", {6'h00, zero_r, carry_r}, 8'h00);
    chk("status_rst", {6'h00, timeout_status_r, powerdown_status_r}, 8'h03);
    chk("discard_rst", {7'h00, discard_r}, 8'h00);
    for (int i = 0; i < 64; i++) begin
      fm[i] = $urandom_range(255, 0);
      bwr(7'(i), 8'(fm[i]));
    end
    // random mix; low register values are forced often so skips and wraps occur
    for (int i = 0; i < 300; i++) begin
      op = $urandom_range(7, 0);
      a  = $urandom_range(63, 0);
      d  = $urandom_range(1, 0);
      v  = $urandom_range(255, 0);
      if (v < 64) begin fm[a] = 1; bwr(7'(a), 8'h01); end
      else if (v < 80) begin fm[a] = 0; bwr(7'(a), 8'h00); end
      if (v[1]) begin m_acc = $urandom_range(255, 0); bwr(ccde_pkg::ADDR_ACC, 8'(m_acc)); end
      if (v[2]) begin
        m_z = v[3]; m_c = v[4];
        bwr(ccde_pkg::ADDR_STATUS, 8'(m_z * 4 + m_c));
      end
      ex(op, a, d, 1'b0);
      chk("acc", acc_r, 8'(m_acc));
      chk("zero", {7'h00, zero_r}, 8'(m_z));
      chk("carry", {7'h00, carry_r}, 8'(m_c));
      chk("discard", {7'h00, discard_r}, 8'(m_sk));
      if (op == 2) chk("kick_st", {6'h00, timeout_status_r, powerdown_status_r}, 8'h03);
      brd({1'b0, 6'(a)});
      chk("file", rd, 8'(fm[a]));
    end
    brd(ccde_pkg::ADDR_STATUS);
    chk("status_reg", rd & 8'h05, 8'(m_z * 4 + m_c));
    // skipping decrement held valid: the repeat in the nop cycle must be dropped
    a = 9;
    fm[a] = 1;
    bwr(7'(a), 8'h01);
    ex(5, a, 1, 1'b1);
    chk("skip_nop", {7'h00, discard_r}, 8'h01);
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1 chk("skip_end", {7'h00, discard_r}, 8'h00);
    brd(7'(a));
    chk("skip_file", rd, 8'h00);
    bwr(7'h50, 8'hA5);
    brd(7'h50);
    chk("unmapped", rd, 8'h00);
    // watchdog: expire, kick, then time the next full period of 256 counts
    bwr(ccde_pkg::ADDR_CTRL, 8'h00);
    n = 0;
    while (wdt_expire_r !== 1'b1 && n < 300) begin @(posedge mclk); #1 n++; end
    chk("wdt_wait", {7'h00, 1'(n < 300)}, 8'h01);
    @(posedge mclk);
    #1 chk("expired_to", {7'h00, timeout_status_r}, 8'h00);
    ex(2, 0, 0, 1'b0);
    chk("kick_st2", {6'h00, timeout_status_r, powerdown_status_r}, 8'h03);
    n = 0;
    while (wdt_expire_r !== 1'b1 && n < 400) begin @(posedge mclk); #1 n++; end
    chk("wdt_period", {7'h00, 1'(n == (1 << 8))}, 8'h01);
    // prescaler not assigned: a kick leaves it counting, four counts on at the second read
    brd(ccde_pkg::ADDR_PRESC);
    n = rd;
    ex(2, 0, 0, 1'b0);
    brd(ccde_pkg::ADDR_PRESC);
    chk("presc_kept", rd, 8'(n + 4));
    // prescaler assigned: a kick zeroes it, one count before the read samples it
    bwr(ccde_pkg::ADDR_CTRL, 8'h01);
    repeat (200) @(posedge mclk);
    ex(2, 0, 0, 1'b0);
    brd(ccde_pkg::ADDR_PRESC);
    chk("presc_clear", rd, 8'h01);
    end_sim();
  end
endmodule // ccde_exec_tb
`default_nettype wire
